/* File: core/ipv_pkg.sv */
package ipv_pkg;
  // Sources in fixed priority order, index 0 highest.
  localparam int NUM_SRC     = 12;
  localparam int SRC_TRAP    = 0;
  localparam int SRC_NMI     = 1;
  localparam int SRC_EXT0    = 2;
  localparam int SRC_EXT1    = 3;
  localparam int SRC_EXT2    = 4;
  localparam int SRC_TMR0    = 5;
  localparam int SRC_TMR1    = 6;
  localparam int SRC_DMA0    = 7;
  localparam int SRC_DMA1    = 8;
  localparam int SRC_CSER    = 9;
  localparam int SRC_SER0    = 10;
  localparam int SRC_SER1    = 11;
  localparam int SRC_W       = 4;

  // Control register bit positions and reset value.
  localparam int              CTL_EXT0_EN_BIT = 0;
  localparam int              CTL_EXT1_EN_BIT = 1;
  localparam logic [7:0]      CTL_RESET       = 8'h00;

  // Vector-table offsets of the internally vectored sources.
  localparam logic [7:0] ext_irq1_vector       = 8'h00;
  localparam logic [7:0] ext_irq2_vector       = 8'h02;
  localparam logic [7:0] reload_timer0_vector  = 8'h04;
  localparam logic [7:0] reload_timer1_vector  = 8'h06;
  localparam logic [7:0] dma_chan0_vector      = 8'h08;
  localparam logic [7:0] dma_chan1_vector      = 8'h0A;
  localparam logic [7:0] clocked_serial_vector = 8'h0C;
  localparam logic [7:0] async_serial0_vector  = 8'h0E;
  localparam logic [7:0] async_serial1_vector  = 8'h10;

  // Direct jump targets.
  localparam logic [15:0] power_fail_jump_vector = 16'h0066;
  localparam logic [15:0] TRAP_JUMP_ADDR         = 16'h0000;
  localparam logic [15:0] EXT0_JUMP_ADDR         = 16'h0038;

  // Dispatch kinds.
  localparam logic [1:0] KIND_NONE   = 2'h0;
  localparam logic [1:0] KIND_VECTOR = 2'h1;
  localparam logic [1:0] KIND_JUMP   = 2'h2;

  // NMI cause codes.
  localparam logic [1:0] CAUSE_NONE   = 2'h0;
  localparam logic [1:0] CAUSE_PFAIL  = 2'h1;
  localparam logic [1:0] CAUSE_SERIAL = 2'h2;

  typedef enum logic [2:0] {
    IPV_IDLE = 3'b001,
    IPV_SERV = 3'b010,
    IPV_DONE = 3'b100
  } ipv_state_t;
endpackage : ipv_pkg

/* File: core/ipv_prio_enc.sv */
`timescale 1ns/1ps
// Picks the lowest-index pending source, which is the highest priority.
module ipv_prio_enc (
  input  wire logic [ipv_pkg::NUM_SRC-1:0] req,    // Pending sources
  output logic                             any,    // Any pending
  output logic [ipv_pkg::SRC_W-1:0]        winner  // Index of winner
);
  always_comb begin
    any    = 1'b0;
    winner = '0;
    for (int i = ipv_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        any    = 1'b1;
        winner = ipv_pkg::SRC_W'(i);
      end
    end
  end
endmodule : ipv_prio_enc

/* File: core/ipv_ctrl.sv */
`timescale 1ns/1ps
module ipv_ctrl (
  input  wire logic        CLK,            // 40 MHz clock
  input  wire logic        RST_N,          // Async reset, active low
  input  wire logic        CTL_WR,         // Control register write strobe
  input  wire logic [7:0]  CTL_WDATA,      // Control register write data
  input  wire logic        EXT_IRQ0_N,     // External level request 0, active low
  input  wire logic        EXT_IRQ1_N,     // External level request 1, active low
  input  wire logic        EXT_IRQ2_N,     // Level 2 request, active low
  input  wire logic        TRAP_REQ,       // Illegal instruction trap
  input  wire logic        PFAIL_REQ,      // Power-fail detect
  input  wire logic        DBG_SER_REQ,    // Debug serial nonmaskable request
  input  wire logic [6:0]  PERIPH_REQ,     // Timer0/1, DMA0/1, clocked serial, serial0/1
  input  wire logic        ACK,            // Processor accepts the dispatch
  output logic [7:0]       CTL_RDATA,      // Control register readback
  output logic             IRQ_VALID,      // Dispatch presented
  output logic [1:0]       IRQ_KIND,       // Vector or jump
  output logic [15:0]      IRQ_ADDR,       // Table offset or jump target
  output logic [3:0]       IRQ_SRC,        // Winning source index
  output logic [1:0]       NMI_CAUSE       // Cause of nonmaskable dispatch
);
  logic [7:0]                     ctl_reg, next_ctl_reg;
  ipv_pkg::ipv_state_t            state, next_state;
  logic                           nmi_edge_prev, next_nmi_edge_prev;
  logic                           nmi_pend, next_nmi_pend;
  logic [1:0]                     nmi_cause_q, next_nmi_cause_q;
  logic                           valid, next_valid;
  logic [1:0]                     kind, next_kind;
  logic [15:0]                    addr, next_addr;
  logic [3:0]                     src, next_src;
  logic [1:0]                     cause, next_cause;
  logic [ipv_pkg::NUM_SRC-1:0]    req;
  logic                           any;
  logic [ipv_pkg::SRC_W-1:0]      winner;
  logic                           nmi_in;

  assign nmi_in = PFAIL_REQ | DBG_SER_REQ;

  // Level requests are sampled live each cycle, so a disabled request leaves no trace.
  always_comb begin
    req                        = '0;
    req[ipv_pkg::SRC_TRAP]     = TRAP_REQ;
    req[ipv_pkg::SRC_NMI]      = nmi_pend;
    req[ipv_pkg::SRC_EXT0]     = ~EXT_IRQ0_N & ctl_reg[ipv_pkg::CTL_EXT0_EN_BIT];
    req[ipv_pkg::SRC_EXT1]     = ~EXT_IRQ1_N & ctl_reg[ipv_pkg::CTL_EXT1_EN_BIT];
    req[ipv_pkg::SRC_EXT2]     = ~EXT_IRQ2_N;
    req[ipv_pkg::SRC_SER1:ipv_pkg::SRC_TMR0] = PERIPH_REQ;
  end

  ipv_prio_enc u_prio (
    .req    (req),
    .any    (any),
    .winner (winner)
  );

  always_comb begin
    next_ctl_reg       = ctl_reg;
    next_state         = state;
    next_nmi_edge_prev = nmi_in;
    next_nmi_pend      = nmi_pend;
    next_nmi_cause_q   = nmi_cause_q;
    next_valid         = valid;
    next_kind          = kind;
    next_addr          = addr;
    next_src           = src;
    next_cause         = cause;
    if (CTL_WR) begin
      next_ctl_reg = CTL_WDATA;
    end
    // The nonmaskable input is edge triggered; power fail outranks serial in the cause.
    if (nmi_in && !nmi_edge_prev) begin
      next_nmi_pend    = 1'b1;
      next_nmi_cause_q = PFAIL_REQ ? ipv_pkg::CAUSE_PFAIL : ipv_pkg::CAUSE_SERIAL;
    end
    case (state)
      ipv_pkg::IPV_IDLE: begin
        if (any) begin
          next_valid = 1'b1;
          next_src   = winner;
          next_cause = ipv_pkg::CAUSE_NONE;
          next_kind  = ipv_pkg::KIND_VECTOR;
          case (winner)
            ipv_pkg::SRC_W'(ipv_pkg::SRC_TRAP): begin
              next_kind = ipv_pkg::KIND_JUMP;
              next_addr = ipv_pkg::TRAP_JUMP_ADDR;
            end
            ipv_pkg::SRC_W'(ipv_pkg::SRC_NMI): begin
              next_kind  = ipv_pkg::KIND_JUMP;
              next_addr  = ipv_pkg::power_fail_jump_vector;
              next_cause = nmi_cause_q;
              // A new edge in this cycle keeps the pending flag set.
              if (!(nmi_in && !nmi_edge_prev)) begin
                next_nmi_pend = 1'b0;
              end
            end
            ipv_pkg::SRC_W'(ipv_pkg::SRC_EXT0): begin
              next_kind = ipv_pkg::KIND_JUMP;
              next_addr = ipv_pkg::EXT0_JUMP_ADDR;
            end
            ipv_pkg::SRC_W'(ipv_pkg::SRC_EXT1): next_addr = {8'h00, ipv_pkg::ext_irq1_vector};
            ipv_pkg::SRC_W'(ipv_pkg::SRC_EXT2): next_addr = {8'h00, ipv_pkg::ext_irq2_vector};
            ipv_pkg::SRC_W'(ipv_pkg::SRC_TMR0): next_addr = {8'h00, ipv_pkg::reload_timer0_vector};
            ipv_pkg::SRC_W'(ipv_pkg::SRC_TMR1): next_addr = {8'h00, ipv_pkg::reload_timer1_vector};
            ipv_pkg::SRC_W'(ipv_pkg::SRC_DMA0): next_addr = {8'h00, ipv_pkg::dma_chan0_vector};
            ipv_pkg::SRC_W'(ipv_pkg::SRC_DMA1): next_addr = {8'h00, ipv_pkg::dma_chan1_vector};
            ipv_pkg::SRC_W'(ipv_pkg::SRC_CSER): next_addr = {8'h00, ipv_pkg::clocked_serial_vector};
            ipv_pkg::SRC_W'(ipv_pkg::SRC_SER0): next_addr = {8'h00, ipv_pkg::async_serial0_vector};
            default:                            next_addr = {8'h00, ipv_pkg::async_serial1_vector};
          endcase
          next_state = ipv_pkg::IPV_SERV;
        end
      end
      ipv_pkg::IPV_SERV: begin
        if (ACK) begin
          next_valid = 1'b0;
          next_state = ipv_pkg::IPV_DONE;
        end
      end
      default: begin
        // One idle cycle lets a level source drop before it is sampled again.
        next_kind  = ipv_pkg::KIND_NONE;
        next_state = ipv_pkg::IPV_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_reg       <= ipv_pkg::CTL_RESET;
      state         <= ipv_pkg::IPV_IDLE;
      nmi_edge_prev <= 1'b0;
      nmi_pend      <= 1'b0;
      nmi_cause_q   <= ipv_pkg::CAUSE_NONE;
      valid         <= 1'b0;
      kind          <= ipv_pkg::KIND_NONE;
      addr          <= 16'h0000;
      src           <= 4'h0;
      cause         <= ipv_pkg::CAUSE_NONE;
    end else begin
      ctl_reg       <= next_ctl_reg;
      state         <= next_state;
      nmi_edge_prev <= next_nmi_edge_prev;
      nmi_pend      <= next_nmi_pend;
      nmi_cause_q   <= next_nmi_cause_q;
      valid         <= next_valid;
      kind          <= next_kind;
      addr          <= next_addr;
      src           <= next_src;
      cause         <= next_cause;
    end
  end

  assign CTL_RDATA = ctl_reg;
  assign IRQ_VALID = valid;
  assign IRQ_KIND  = kind;
  assign IRQ_ADDR  = addr;
  assign IRQ_SRC   = src;
  assign NMI_CAUSE = cause;
endmodule : ipv_ctrl

/* File: bench/ipv_ctrl_properties.sv */
`timescale 1ns/1ps
module ipv_ctrl_chk (
  input wire logic        CLK,       // Clock
  input wire logic        RST_N,     // Reset, active low
  input wire logic        CTL_WR,    // Write strobe
  input wire logic [7:0]  CTL_WDATA, // Write data
  input wire logic [7:0]  CTL_RDATA, // Control readback
  input wire logic        TRAP_REQ,  // Trap level
  input wire logic        ACK,       // Dispatch accepted
  input wire logic        IRQ_VALID, // Dispatch presented
  input wire logic [1:0]  IRQ_KIND,  // Dispatch kind
  input wire logic [15:0] IRQ_ADDR,  // Offset or target
  input wire logic [3:0]  IRQ_SRC,   // Winner index
  input wire logic [1:0]  NMI_CAUSE  // Nonmaskable cause
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence release_s;
    !IRQ_VALID ##1 IRQ_KIND == 2'h0;
  endsequence
  hold_dispatch_a: assert property (IRQ_VALID && !ACK |=> IRQ_VALID && $stable(IRQ_ADDR) && $stable(IRQ_SRC))
    else $error("dispatch changed before ack");
  ack_release_a: assert property (IRQ_VALID && ACK |=> release_s)
    else $error("dispatch not released after ack");
  nmi_target_a: assert property (IRQ_VALID && IRQ_SRC == 4'h1 |-> IRQ_KIND == 2'h2 && IRQ_ADDR == 16'h0066)
    else $error("nonmaskable target wrong");
  nmi_cause_a: assert property (IRQ_VALID && IRQ_SRC == 4'h1 |-> NMI_CAUSE != 2'h0)
    else $error("nonmaskable cause missing");
  vec_offset_a: assert property (IRQ_VALID && IRQ_SRC >= 4'h3 |-> IRQ_KIND == 2'h1 && IRQ_ADDR == {11'h000, IRQ_SRC - 4'h3, 1'b0})
    else $error("vector offset wrong");
  ctl_store_a: assert property (CTL_WR |=> CTL_RDATA == $past(CTL_WDATA))
    else $error("control write not stored");
  ext0_gate_a: assert property ($rose(IRQ_VALID) && IRQ_SRC == 4'h2 |-> $past(CTL_RDATA[0]))
    else $error("disabled request 0 dispatched");
  ext1_gate_a: assert property ($rose(IRQ_VALID) && IRQ_SRC == 4'h3 |-> $past(CTL_RDATA[1]))
    else $error("disabled request 1 dispatched");
  trap_first_a: assert property ($rose(IRQ_VALID) && $past(TRAP_REQ) |-> IRQ_SRC == 4'h0)
    else $error("trap not first");
endmodule : ipv_ctrl_chk
bind ipv_ctrl ipv_ctrl_chk u_chk (.*);

/* File: bench/ipv_irq_src.sv */
`timescale 1ns/1ps
// Each raised source holds its level until its own dispatch is accepted, so an unserviced request never vanishes.
module ipv_irq_src (
  input  wire logic        clk,    // Clock
  input  wire logic        rst_n,  // Reset, active low
  input  wire logic [11:0] raise,  // Request pulses by source index
  input  wire logic        valid,  // Dispatch presented
  input  wire logic        ack,    // Dispatch accepted
  input  wire logic [3:0]  src,    // Dispatched source
  output logic             trap,   // Trap level
  output logic [2:0]       ext_n,  // External levels, active low
  output logic [6:0]       periph  // Peripheral levels
);
  logic [11:0] lvl;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl <= 12'h000;
    end else begin
      lvl <= (lvl | raise) & ~((valid && ack) ? (12'h001 << src) : 12'h000);
    end
  end
  assign trap   = lvl[0];
  assign ext_n  = ~lvl[4:2];
  assign periph = lvl[11:5];
endmodule : ipv_irq_src

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct {logic [11:0] m; logic [3:0] s; logic [1:0] k; logic [15:0] a;} ipv_row_t;
  logic CLK = 1'b0, RST_N = 1'b0, CTL_WR = 1'b0, ACK = 1'b0, PFAIL_REQ = 1'b0, DBG_SER_REQ = 1'b0, TRAP_REQ;
  logic [7:0] CTL_WDATA = 8'h00, CTL_RDATA;
  logic [11:0] raise = 12'h000;
  logic [2:0] ext_n;
  logic [6:0] PERIPH_REQ;
  logic IRQ_VALID, seen;
  logic [1:0] IRQ_KIND, NMI_CAUSE;
  logic [15:0] IRQ_ADDR;
  logic [3:0] IRQ_SRC;
  int miscompares = 0, n_checks = 0, cyc = 0;
  ipv_row_t rows [12] = '{'{12'h001, 4'h0, 2'h2, 16'h0000}, '{12'h004, 4'h2, 2'h2, 16'h0038},
    '{12'h018, 4'h3, 2'h1, 16'h0000}, '{12'h010, 4'h4, 2'h1, 16'h0002}, '{12'hFE0, 4'h5, 2'h1, 16'h0004},
    '{12'h040, 4'h6, 2'h1, 16'h0006}, '{12'h080, 4'h7, 2'h1, 16'h0008}, '{12'h100, 4'h8, 2'h1, 16'h000A},
    '{12'h200, 4'h9, 2'h1, 16'h000C}, '{12'h400, 4'hA, 2'h1, 16'h000E}, '{12'h800, 4'hB, 2'h1, 16'h0010},
    '{12'hFFD, 4'h0, 2'h2, 16'h0000}};
  ipv_irq_src u_src (.clk(CLK), .rst_n(RST_N), .raise(raise), .valid(IRQ_VALID), .ack(ACK), .src(IRQ_SRC),
    .trap(TRAP_REQ), .ext_n(ext_n), .periph(PERIPH_REQ));
  ipv_ctrl DUT (.CLK(CLK), .RST_N(RST_N), .CTL_WR(CTL_WR), .CTL_WDATA(CTL_WDATA), .EXT_IRQ0_N(ext_n[0]),
    .EXT_IRQ1_N(ext_n[1]), .EXT_IRQ2_N(ext_n[2]), .TRAP_REQ(TRAP_REQ), .PFAIL_REQ(PFAIL_REQ),
    .DBG_SER_REQ(DBG_SER_REQ), .PERIPH_REQ(PERIPH_REQ), .ACK(ACK), .CTL_RDATA(CTL_RDATA), .IRQ_VALID(IRQ_VALID),
    .IRQ_KIND(IRQ_KIND), .IRQ_ADDR(IRQ_ADDR), .IRQ_SRC(IRQ_SRC), .NMI_CAUSE(NMI_CAUSE));
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_valid(input int lim, output logic hit);
    hit = 1'b0;
    repeat (lim) begin
      @(posedge CLK);
      #1;
      if (IRQ_VALID === 1'b1) begin
        hit = 1'b1;
        break;
      end
    end
  endtask : wait_valid
  // The idle wait after the ack covers the one cycle in which the kind field is still clearing.
  task automatic serve;
    @(posedge CLK) ACK <= 1'b1;
    @(posedge CLK) ACK <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : serve
  task automatic expect_irq(input logic [3:0] s, input logic [1:0] k, input logic [15:0] a);
    logic hit;
    wait_valid(20, hit);
    chk({12'h000, IRQ_SRC}, {12'h000, s});
    chk({14'h0000, IRQ_KIND}, {14'h0000, k});
    chk(IRQ_ADDR, a);
    chk({15'h0000, hit}, 16'h0001);
    serve();
  endtask : expect_irq
  task automatic wr(input logic [7:0] d);
    @(posedge CLK) begin
      CTL_WR <= 1'b1;
      CTL_WDATA <= d;
    end
    @(posedge CLK) CTL_WR <= 1'b0;
    #1 chk({8'h00, CTL_RDATA}, {8'h00, d});
  endtask : wr
  task automatic fire(input logic [11:0] m);
    @(posedge CLK) raise <= m;
    @(posedge CLK) raise <= 12'h000;
  endtask : fire
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    #1 chk({5'h00, CTL_RDATA, IRQ_VALID, IRQ_KIND}, 16'h0000);
    wr(8'h00 | 8'h01 | 8'h02);
    foreach (rows[i]) begin
      fire(rows[i].m);
      expect_irq(rows[i].s, rows[i].k, rows[i].a);
      repeat (12) begin
        wait_valid(6, seen);
        if (seen) serve();
      end
    end
    wr(8'h03 & 8'hFE);
    fire(12'h004);
    wait_valid(10, seen);
    chk({15'h0000, seen}, 16'h0000);
    wr(8'h02 | 8'h01);
    expect_irq(4'h2, 2'h2, 16'h0038);
    wr(8'h03 & 8'hFD);
    fire(12'h008);
    wait_valid(10, seen);
    chk({15'h0000, seen}, 16'h0000);
    wr(8'h01 | 8'h02);
    expect_irq(4'h3, 2'h1, 16'h0000);
    @(posedge CLK) PFAIL_REQ <= 1'b1;
    wait_valid(10, seen);
    chk({14'h0000, NMI_CAUSE}, 16'h0001);
    expect_irq(4'h1, 2'h2, ipv_pkg::power_fail_jump_vector);
    // The shared nonmaskable input only reacts to a rising edge, so power fail must drop first.
    @(posedge CLK) PFAIL_REQ <= 1'b0;
    @(posedge CLK) DBG_SER_REQ <= 1'b1;
    wait_valid(10, seen);
    chk({14'h0000, NMI_CAUSE}, 16'h0002);
    expect_irq(4'h1, 2'h2, ipv_pkg::power_fail_jump_vector);
    @(posedge CLK) DBG_SER_REQ <= 1'b0;
    fire(12'h020);
    wait_valid(10, seen);
    chk({15'h0000, seen}, 16'h0001);
    // A reset in mid-dispatch must drop the dispatch and leave both external requests disabled.
    @(posedge CLK) RST_N <= 1'b0;
    #1 chk({5'h00, CTL_RDATA, IRQ_VALID, IRQ_KIND}, 16'h0000);
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    fire(12'h004);
    wait_valid(10, seen);
    chk({15'h0000, seen}, 16'h0000);
    results();
  end
endmodule : tb
